/* gated_event_totalizer.v */
// Gated event totalizer core with Wishbone register slave
//
// Function
// - In single-channel totalize the gate stays open and every conditioned pulse is counted until stopped.
// - An alternative totalize arrangement counts events on a third channel.
// - In that arrangement a first-channel event opens the gate and a second-channel event closes it.
// - The interval may instead follow a manual start/stop control driven by the operator.
// - Putting the control to start opens the gate and counts channel A, or channels A and B in two-channel totalizing.
// - Moving the control to stop closes the gate and holds the total.
// - Two-channel totalizing reports the sum or the difference as the selector chooses.
// - Normalizing reports the measured frequency times a stored scaling constant.
// - The scaling constant comes either from external switches or from an internal store.
// - A preset output asserts once the displayed count exceeds the loaded preset value.
// - With prescaling on, the counted pulse train is divided by N before the gate.
// - With prescaling by N the normalizing gate-open time is stretched N-fold.
// - A count needs a crossing of both hysteresis thresholds; ringing on one gives none.
// - Positive slope counts when a rising input crosses the upper threshold.
// - Negative slope counts when a falling input crosses the lower threshold.
// - Each pulse reaching the open gate counts once; pulses with the gate shut are ignored.
`timescale 1ns/10ps
`include "gated_totalizer_map.vh"
module gated_event_totalizer (
  input wire core_clk, // 125 MHz core clock
  input wire arst_n, // Asynchronous reset, active low
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte lanes
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire [2:0] chUpper, // Above upper threshold, channels A, B, C
  input wire [2:0] chLower, // Below lower threshold, channels A, B, C
  input wire [`SCALE_W-1:0] scaleSwitch, // External scaling switches
  output reg gateOpen, // Main gate open
  output reg presetOut, // Display above preset
  output reg [`CNT_W-1:0] displayValue // Displayed result
);
  // Gate state codes, one-hot
  localparam [`STATE_W-1:0] ST_IDLE = 3'h1;
  localparam [`STATE_W-1:0] ST_OPEN = 3'h2;
  localparam [`STATE_W-1:0] ST_HELD = 3'h4;
  localparam integer GATE_CYCLES = `GATE_TIME_MS * `CLK_KHZ;
  localparam [`CNT_W-1:0] GATE_RST = GATE_CYCLES[`CNT_W-1:0];

  // Reset synchroniser stages
  reg rstMeta;
  reg rstSyncN;

  // Software-visible registers
  reg [`CTRL_W-1:0] ctrl;
  reg [`PRESC_W-1:0] prescaleN;
  reg [`CNT_W-1:0] gateTicks;
  reg [`SCALE_W-1:0] scaleMem;
  reg [`CNT_W-1:0] presetVal;

  // Gate machine
  reg [`STATE_W-1:0] state;
  reg [`STATE_W-1:0] next_state;

  // Counting registers and gate timer
  reg [`CNT_W-1:0] countA;
  reg [`CNT_W-1:0] countB;
  reg [`CNT_W-1:0] tickCnt;
  reg [`PRESC_W-1:0] epochCnt;

  // Read mux and gate events
  reg [31:0] rdMux;
  reg startEv;
  reg stopEv;

  // Pulse paths
  wire [2:0] trigPulse;
  wire [1:0] scaledPulse;
  wire [1:0] rawCounted;

  // Bus decode
  wire [31:0] wrWord;
  wire wbReq;
  wire wbWrite;

  // Control fields and gate timing
  wire [1:0] mode;
  wire run;
  wire stOpen;
  wire enterOpen;
  wire [`PRESC_W-1:0] effFactor;
  wire tickLast;
  wire epochLast;
  wire gateDone;
  wire [`SCALE_W-1:0] scaleVal;
  wire [`CNT_W+`SCALE_W-1:0] product;
  wire [`CNT_W-1:0] liveTotal;

  // Merge write data into a word by byte lane
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        laneMerge[i*8 +: 8] = sel[i] ? din[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // Reset release through two flip-flops
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // Control field decode
  assign mode = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign run = ctrl[`CTRL_RUN];
  assign stOpen = state[1];
  assign effFactor = (ctrl[`CTRL_PRESC_EN] && (prescaleN != {`PRESC_W{1'b0}})) ? prescaleN : `FACTOR_ONE;
  assign scaleVal = ctrl[`CTRL_SCALE_SW] ? scaleSwitch : scaleMem;

  // Wishbone request decode
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWrite = wbReq & wb_we_i;
  assign wrWord = laneMerge(rdMux, wb_dat_i, wb_sel_i);

  // Read data selection, unmapped reads as zero
  always @* begin
    case (wb_adr_i)
      `ADR_CTRL: rdMux = {{(32-`CTRL_W){1'b0}}, ctrl};
      `ADR_STATUS: rdMux = {{(29-`STATE_W){1'b0}}, state, presetOut, gateOpen, 1'b0};
      `ADR_PRESCALE: rdMux = {{(32-`PRESC_W){1'b0}}, prescaleN};
      `ADR_GATE: rdMux = gateTicks;
      `ADR_SCALE: rdMux = {{(32-`SCALE_W){1'b0}}, scaleMem};
      `ADR_PRESET: rdMux = presetVal;
      `ADR_RESULT: rdMux = displayValue;
      `ADR_COUNTA: rdMux = countA;
      `ADR_COUNTB: rdMux = countB;
      default: rdMux = 32'h00000000;
    endcase
  end

  // Request masked while ack is high, so one request gives one ack
  // Bus answer one cycle after the request
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? rdMux : 32'h00000000;
    end
  end

  // Writable registers
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ctrl <= `CTRL_RST;
      prescaleN <= `PRESCALE_RST;
      gateTicks <= GATE_RST;
      scaleMem <= `SCALE_RST;
      presetVal <= `PRESET_RST;
    end else if (wbWrite) begin
      case (wb_adr_i)
        `ADR_CTRL: ctrl <= wrWord[`CTRL_W-1:0];
        `ADR_PRESCALE: prescaleN <= wrWord[`PRESC_W-1:0];
        `ADR_GATE: gateTicks <= wrWord;
        `ADR_SCALE: scaleMem <= wrWord[`SCALE_W-1:0];
        `ADR_PRESET: presetVal <= wrWord;
        default: ;
      endcase
    end
  end

  // Input triggers, one per channel
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : trig
      hyst_trigger uTrig (
        .clk(core_clk),
        .rstN(rstSyncN),
        .aboveUpper(chUpper[g]),
        .belowLower(chLower[g]),
        .slopeNeg(ctrl[`CTRL_SLOPE_LO+g]),
        .countPulse(trigPulse[g])
      );
    end
  endgenerate

  // Counted channels: C in third-channel mode, else A; B as second
  assign rawCounted[0] = (mode == `MODE_TOT_CH3) ? trigPulse[2] : trigPulse[0];
  assign rawCounted[1] = trigPulse[1];
  assign enterOpen = startEv & ~stOpen;

  // Prescalers ahead of the gate
  generate
    for (g = 0; g < 2; g = g + 1) begin : presc
      pulse_prescaler uPresc (
        .clk(core_clk),
        .rstN(rstSyncN),
        .clear(enterOpen),
        .factor(effFactor),
        .pulseIn(rawCounted[g]),
        .pulseOut(scaledPulse[g])
      );
    end
  endgenerate

  // Timed gate for normalizing, stretched by the prescale factor
  assign tickLast = ({1'b0, tickCnt} + 33'h000000001) >= {1'b0, gateTicks};
  assign epochLast = ({1'b0, epochCnt} + 9'h001) >= {1'b0, effFactor};
  assign gateDone = tickLast & epochLast;

  // Start and stop events per mode
  always @* begin
    case (mode)
      `MODE_TOT_MANUAL: begin
        startEv = run;
        stopEv = ~run;
      end
      `MODE_TOT_CH3: begin
        startEv = run & trigPulse[0];
        stopEv = ~run | trigPulse[1];
      end
      `MODE_TOT_SUM: begin
        startEv = run;
        stopEv = ~run;
      end
      default: begin
        startEv = run;
        stopEv = ~run | gateDone;
      end
    endcase
  end

  // Held keeps the total readable; a fresh start reopens and clears
  // Gate state transitions
  always @* begin
    case (state)
      ST_IDLE: next_state = startEv ? ST_OPEN : ST_IDLE;
      ST_OPEN: next_state = stopEv ? ST_HELD : ST_OPEN;
      ST_HELD: next_state = startEv ? ST_OPEN : ST_HELD;
      default: next_state = ST_IDLE;
    endcase
  end

  // Gate state and gate output
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state <= ST_IDLE;
      gateOpen <= 1'b0;
    end else begin
      state <= next_state;
      gateOpen <= next_state[1];
    end
  end

  // Counting registers and gate timer
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      countA <= {`CNT_W{1'b0}};
      countB <= {`CNT_W{1'b0}};
      tickCnt <= {`CNT_W{1'b0}};
      epochCnt <= {`PRESC_W{1'b0}};
    end else if (enterOpen) begin
      countA <= {`CNT_W{1'b0}};
      countB <= {`CNT_W{1'b0}};
      tickCnt <= {`CNT_W{1'b0}};
      epochCnt <= {`PRESC_W{1'b0}};
    end else if (stOpen) begin
      if (scaledPulse[0]) begin
        countA <= countA + 32'h00000001;
      end
      if (scaledPulse[1] && (mode == `MODE_TOT_SUM)) begin
        countB <= countB + 32'h00000001;
      end
      if (tickLast) begin
        tickCnt <= {`CNT_W{1'b0}};
        epochCnt <= epochCnt + `FACTOR_ONE;
      end else begin
        tickCnt <= tickCnt + 32'h00000001;
      end
    end
  end

  // Result forming: sum, difference, scaled frequency
  assign liveTotal = (mode != `MODE_TOT_SUM) ? countA :
    (ctrl[`CTRL_SUMDIFF] ? countA - countB : countA + countB);
  assign product = countA * scaleVal;

  // Preset compare uses the registered display, so it lags one cycle
  // Display register and preset compare
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      displayValue <= {`CNT_W{1'b0}};
      presetOut <= 1'b0;
    end else begin
      if (mode == `MODE_NORMALIZE) begin
        if (stOpen && stopEv) begin
          displayValue <= product[`CNT_W-1:0];
        end
      end else if (state != ST_IDLE) begin
        displayValue <= liveTotal;
      end
      presetOut <= displayValue > presetVal;
    end
  end
endmodule // gated_event_totalizer

/* gated_totalizer_map.vh */
// Register map, field positions, reset values and timing for the gated event totalizer
`ifndef GATED_TOTALIZER_MAP_VH
`define GATED_TOTALIZER_MAP_VH

// Register byte offsets
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_PRESCALE 8'h08
`define ADR_GATE 8'h0C
`define ADR_SCALE 8'h10
`define ADR_PRESET 8'h14
`define ADR_RESULT 8'h18
`define ADR_COUNTA 8'h1C
`define ADR_COUNTB 8'h20

// Control register fields
`define CTRL_W 9
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_RUN 2
`define CTRL_SUMDIFF 3
`define CTRL_PRESC_EN 4
`define CTRL_SCALE_SW 5
`define CTRL_SLOPE_LO 6

// Measurement modes
`define MODE_TOT_MANUAL 2'h0
`define MODE_TOT_CH3 2'h1
`define MODE_TOT_SUM 2'h2
`define MODE_NORMALIZE 2'h3

// Widths
`define CNT_W 32
`define SCALE_W 16
`define PRESC_W 8
`define STATE_W 3

// Reset values
`define CTRL_RST 9'h000
`define PRESCALE_RST 8'h01
`define SCALE_RST 16'h0001
`define PRESET_RST 32'hFFFFFFFF
`define FACTOR_ONE 8'h01

// Gate time for normalizing, in milliseconds, and the clock in kHz
`define GATE_TIME_MS 1000
`define CLK_KHZ 125000

`endif

/* gated_totalizer_properties.sv */
// Checker of bus answer, gate and preset behaviour of the totalizer
`timescale 1ns/10ps
module gated_totalizer_checker (
  input wire core_clk, // Clock
  input wire arst_n, // Reset, active low
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [7:0] wb_adr_i, // Address
  input wire [3:0] wb_sel_i, // Lanes
  input wire [31:0] wb_dat_i, // Write data
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Acknowledge
  input wire gateOpen, // Gate
  input wire presetOut, // Preset output
  input wire [31:0] displayValue // Display
);
  reg [31:0] presetVal;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ctrlWrite;
    taken ##0 (wb_we_i && wb_adr_i == 8'h00 && wb_sel_i == 4'hF && !wb_dat_i[0]);
  endsequence
  // Shadow of the preset value
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      presetVal <= 32'hFFFFFFFF;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h14 && wb_sel_i == 4'hF) begin
      presetVal <= wb_dat_i;
    end
  end
  // Bus answer
  ack_latency_a: assert property (taken |=> wb_ack_o) else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  // Gate and result
  gate_start_a: assert property (ctrlWrite ##0 wb_dat_i[2] |-> ##[1:3] gateOpen)
    else $error("gate not opened");
  gate_stop_a: assert property (ctrlWrite ##0 !wb_dat_i[2] |-> ##[1:3] !gateOpen)
    else $error("gate not closed");
  preset_cmp_a: assert property (presetOut == ($past(displayValue) > $past(presetVal)))
    else $error("preset output wrong");
  display_hold_a: assert property ((!gateOpen && !wb_cyc_i) [*6] |-> $stable(displayValue))
    else $error("display moved while closed");
endmodule // gated_totalizer_checker

bind gated_event_totalizer gated_totalizer_checker i_checker (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .gateOpen, .presetOut, .displayValue);

/* hyst_trigger.v */
// Hysteresis trigger with slope select, one count pulse per full swing
`timescale 1ns/10ps
module hyst_trigger (
  input wire clk, // Core clock
  input wire rstN, // Synchronised reset, active low
  input wire aboveUpper, // Input is above the upper threshold
  input wire belowLower, // Input is below the lower threshold
  input wire slopeNeg, // 1 selects negative slope
  output reg countPulse // One-cycle count pulse
);
  reg armed;

  // Arm on the opposite threshold, fire on the selected one
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      armed <= 1'b0;
      countPulse <= 1'b0;
    end else begin
      countPulse <= 1'b0;
      if (!slopeNeg) begin
        if (belowLower) begin
          armed <= 1'b1;
        end else if (aboveUpper && armed) begin
          armed <= 1'b0;
          countPulse <= 1'b1;
        end
      end else begin
        if (aboveUpper) begin
          armed <= 1'b1;
        end else if (belowLower && armed) begin
          armed <= 1'b0;
          countPulse <= 1'b1;
        end
      end
    end
  end
endmodule // hyst_trigger

/* pulse_prescaler.v */
// Divide-by-N prescaler for a pulse train
`timescale 1ns/10ps
`include "gated_totalizer_map.vh"
module pulse_prescaler (
  input wire clk, // Core clock
  input wire rstN, // Synchronised reset, active low
  input wire clear, // Restart division at gate opening
  input wire [`PRESC_W-1:0] factor, // Division factor, 1 passes through
  input wire pulseIn, // Conditioned pulses
  output reg pulseOut // One pulse per factor inputs
);
  reg [`PRESC_W-1:0] divCnt;
  wire lastOne = ({1'b0, divCnt} + 9'h001) >= {1'b0, factor};

  // Count input pulses, emit one per N
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      divCnt <= {`PRESC_W{1'b0}};
      pulseOut <= 1'b0;
    end else if (clear) begin
      divCnt <= {`PRESC_W{1'b0}};
      pulseOut <= 1'b0;
    end else begin
      pulseOut <= 1'b0;
      if (pulseIn) begin
        if (lastOne) begin
          divCnt <= {`PRESC_W{1'b0}};
          pulseOut <= 1'b1;
        end else begin
          divCnt <= divCnt + `FACTOR_ONE;
        end
      end
    end
  end
endmodule // pulse_prescaler

/* pulse_source.sv */
// Model of the conditioned channel inputs making threshold swings
`timescale 1ns/10ps
module pulse_source (
  input wire clk, // Clock
  input wire [2:0] req, // Start a swing on these channels
  input wire fall, // Upper threshold first
  input wire ring, // Upper threshold only
  output wire [2:0] chUpper, // Above upper
  output wire [2:0] chLower // Below lower
);
  reg [2:0] ch = 3'h0;
  reg [1:0] step = 2'h0;
  wire upOn;
  wire loOn;
  // Steps: first level, second level, middle
  always @(posedge clk) begin
    if (step != 2'h0) begin
      step <= step + 2'h1;
    end else if (req != 3'h0) begin
      ch <= req;
      step <= 2'h1;
    end
  end
  // Levels per step
  assign upOn = (step == 2'h1 && (ring || fall)) || (step == 2'h2 && !ring && !fall);
  assign loOn = (step == 2'h1 && !ring && !fall) || (step == 2'h2 && !ring && fall);
  assign chUpper = ch & {3{upOn}};
  assign chLower = ch & {3{loOn}};
endmodule // pulse_source

/* testbench.sv */
// Self-checking bench of the gated event totalizer
`timescale 1ns/10ps
module testbench;
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg strobe = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0;
  reg [3:0] sel = 4'hF;
  reg [3:0] ws = 4'hF;
  reg [2:0] req = 3'h0;
  reg fall = 1'b0;
  reg ring = 1'b0;
  reg [31:0] rd;
  wire [31:0] rdat;
  wire [31:0] disp;
  wire [2:0] up;
  wire [2:0] lo;
  wire ack;
  wire gate;
  wire preset;
  integer errors = 0;
  integer samples_checked = 0;
  integer k;
  integer n;
  // Clock
  always #4 core_clk = ~core_clk;
  // Design and channel model
  gated_event_totalizer i_dut (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(strobe), .wb_stb_i(strobe),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .chUpper(up), .chLower(lo), .scaleSwitch(16'h0007), .gateOpen(gate), .presetOut(preset), .displayValue(disp));
  pulse_source i_source (.clk(core_clk), .req(req), .fall(fall), .ring(ring), .chUpper(up), .chLower(lo));
  // Verdict
  task summarize;
    begin
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // Comparison
  task check(input [63:0] name, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Bounded wait ran out
  task stuck;
    begin
      check("wait", 32'h0, 32'h1);
      summarize;
    end
  endtask
  // One bus cycle
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      strobe <= 1'b1;
      we <= w;
      adr <= a;
      sel <= ws;
      wdat <= d;
      n = 0;
      @(posedge core_clk);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge core_clk);
        n = n + 1;
      end
      if (n == 20) begin
        stuck;
      end
      rd = rdat;
      strobe <= 1'b0;
    end
  endtask
  // Register read and compare
  task rdc(input [7:0] a, input [31:0] e, input [63:0] name);
    begin
      bus(1'b0, a, 32'h0);
      check(name, e, rd);
    end
  endtask
  // Wait for the gate level
  task waitGate(input v);
    begin
      n = 0;
      while (gate !== v && n < 400) begin
        @(posedge core_clk);
        n = n + 1;
      end
      if (n == 400) begin
        stuck;
      end
    end
  endtask
  // Threshold swings
  task swing(input [2:0] c, input integer cnt);
    integer i;
    begin
      for (i = 0; i < cnt; i = i + 1) begin
        @(posedge core_clk);
        req <= c;
        @(posedge core_clk);
        req <= 3'h0;
        repeat (3) @(posedge core_clk);
      end
    end
  endtask
  // Test sequence
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(8'h00, 32'h0, "ctrl");
    rdc(8'h08, 32'h1, "presc");
    rdc(8'h0C, 32'h07735940, "gatelen");
    rdc(8'h10, 32'h1, "scale");
    rdc(8'h14, 32'hFFFFFFFF, "preset");
    bus(1'b1, 8'h04, 32'hFFFFFFFF);
    rdc(8'h04, 32'h8, "status");
    rdc(8'h3C, 32'h0, "unmapped");
    // Manual start and stop, ringing, closed gate
    swing(3'h1, 2);
    bus(1'b1, 8'h00, 32'h4);
    waitGate(1'b1);
    swing(3'h1, 4);
    ring <= 1'b1;
    swing(3'h1, 2);
    ring <= 1'b0;
    bus(1'b1, 8'h00, 32'h0);
    swing(3'h1, 2);
    rdc(8'h1C, 32'h4, "countA");
    check("display", 32'h4, disp);
    bus(1'b1, 8'h00, 32'h44);
    waitGate(1'b1);
    rdc(8'h1C, 32'h0, "cleared");
    fall <= 1'b1;
    swing(3'h1, 3);
    fall <= 1'b0;
    bus(1'b1, 8'h00, 32'h40);
    rdc(8'h1C, 32'h3, "negslope");
    // Sum, difference and preset of 7
    bus(1'b1, 8'h14, 32'h7);
    for (k = 0; k < 2; k = k + 1) begin
      bus(1'b1, 8'h00, k ? 32'hE : 32'h6);
      waitGate(1'b1);
      swing(3'h3, 3);
      swing(3'h1, 2);
      bus(1'b1, 8'h00, k ? 32'hA : 32'h2);
      rdc(8'h18, k ? 32'h2 : 32'h8, "result");
      check("preset", k ? 32'h0 : 32'h1, {31'h0, preset});
    end
    // Third channel between opening and closing events
    bus(1'b1, 8'h00, 32'h5);
    swing(3'h4, 2);
    swing(3'h1, 1);
    waitGate(1'b1);
    swing(3'h4, 3);
    swing(3'h2, 1);
    waitGate(1'b0);
    swing(3'h4, 2);
    check("display", 32'h3, disp);
    bus(1'b1, 8'h00, 32'h1);
    // Normalizing, prescale 2, 40 tick gate
    bus(1'b1, 8'h0C, 32'h28);
    ws = 4'h1;
    bus(1'b1, 8'h10, 32'hFFFFFF03);
    ws = 4'hF;
    rdc(8'h10, 32'h3, "lanes");
    bus(1'b1, 8'h08, 32'h2);
    for (k = 0; k < 2; k = k + 1) begin
      bus(1'b1, 8'h00, k ? 32'h37 : 32'h17);
      waitGate(1'b1);
      swing(3'h1, 6);
      waitGate(1'b0);
      check("normal", k ? 32'h15 : 32'h9, disp);
      waitGate(1'b1);
      n = 0;
      while (gate === 1'b1 && n < 300) begin
        @(posedge core_clk);
        n = n + 1;
      end
      check("gatelen", 32'h50, n);
      bus(1'b1, 8'h00, 32'h0);
    end
    summarize;
  end
endmodule // testbench
